// ---- rtl/trace_regs.svh ----
// Purpose: register offsets, field positions and reset values
// Assumes: AHB-Lite word registers, byte offsets on haddr[7:0]
// Notes: included by its bare name
`ifndef TRACE_REGS_SVH
`define TRACE_REGS_SVH

`define OFS_CTRL 8'h00
`define OFS_POINTS 8'h04
`define OFS_SPAN 8'h08
`define OFS_SWEEP 8'h0c
`define OFS_STATUS 8'h10
`define OFS_INDEX 8'h14
`define OFS_FSTEP 8'h18
`define OFS_TSTEP 8'h1c

`define CTRL_START 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 3
`define CTRL_IQ 4

`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_UNSUP 2

`define PTS_MIN 14'h0065
`define PTS_MAX 14'h2000
`define PTS_RST 14'h0065
`define SPAN_RST 32'h0000_0000
`define SWEEP_RST 32'h0000_0000
`define TSTEP_MIN 32'h0000_0002
`define DIV_STEPS 6'h20

`endif

// ---- rtl/trace_pkg.sv ----
// Purpose: shared types of the trace bucket detector
// Assumes: nothing
// Notes: detector codes 3'h6 and 3'h7 are illegal
package trace_pkg;
    typedef enum logic [2:0] {
        DET_SAMPLE = 3'h0,
        DET_MAX = 3'h1,
        DET_MIN = 3'h2,
        DET_NORMAL = 3'h3,
        DET_AVERAGE = 3'h4,
        DET_QPEAK = 3'h5
    } det_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV = 2'b01,
        ST_RUN = 2'b11
    } state_e;
endpackage

// ---- rtl/trace_buf.sv ----
// Purpose: two-entry buffer between bucket engine and trace memory
// Assumes: one clock, synchronous active-high reset
// Notes: all outputs are flip-flops; in_ready low means both slots full
`timescale 1ns/1ps
module trace_buf #(
    parameter int W = 46
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] head_r, head_nxt, tail_r, tail_nxt;
    logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt, rdy_r, rdy_nxt;

    always_comb begin
        head_nxt = head_r;
        head_v_nxt = head_v_r;
        tail_nxt = tail_r;
        tail_v_nxt = tail_v_r;
        if (head_v_r && out_ready_i) begin
            if (tail_v_r) begin
                head_nxt = tail_r;
                tail_v_nxt = 1'b0;
            end else begin
                head_v_nxt = 1'b0;
            end
        end
        if (in_valid_i && rdy_r) begin
            if (!head_v_nxt) begin
                head_nxt = in_data_i;
                head_v_nxt = 1'b1;
            end else begin
                tail_nxt = in_data_i;
                tail_v_nxt = 1'b1;
            end
        end
        rdy_nxt = !tail_v_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            head_r <= '0;
            tail_r <= '0;
            head_v_r <= 1'b0;
            tail_v_r <= 1'b0;
            rdy_r <= 1'b1;
        end else begin
            head_r <= head_nxt;
            tail_r <= tail_nxt;
            head_v_r <= head_v_nxt;
            tail_v_r <= tail_v_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign in_ready_o = rdy_r;
    assign out_valid_o = head_v_r;
    assign out_data_o = head_r;
endmodule

// ---- rtl/trace_bucket_detector.sv ----
// Purpose: groups envelope samples into trace-point buckets and reduces them
// Assumes: AHB-Lite slave, zero wait states, single clock
// Notes: average and quasi-peak codes fall back to sample and flag status
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "trace_regs.svh"
module trace_bucket_detector #(
    parameter int IW = 13
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic SAMPLE_VALID_I,
    output logic SAMPLE_READY_O,
    input wire logic [15:0] SAMPLE_I_I,
    input wire logic [15:0] SAMPLE_Q_I,
    input wire logic [15:0] SAMPLE_VIDEO_I,
    output logic TRACE_VALID_O,
    input wire logic TRACE_READY_I,
    output logic [IW-1:0] TRACE_ADDR_O,
    output logic [15:0] TRACE_DATA_O,
    output logic [15:0] TRACE_PREV_O,
    output logic TRACE_LAST_O
);
    localparam int BW = IW + 33;

    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [15:0] root;
        logic [15:0] c;
        root = 16'h0;
        for (int b = 15; b >= 0; b--) begin
            c = root | 16'(17'h1 << b);
            if ({16'h0, c} * {16'h0, c} <= v) begin
                root = c;
            end
        end
        return root;
    endfunction

    // one restoring step; the quotient shifts into the dividend's place
    function automatic logic [46:0] div_step(input logic [14:0] rem,
        input logic [31:0] nq, input logic [13:0] den);
        logic [14:0] t;
        t = {rem[13:0], nq[31]};
        if (t >= {1'b0, den}) begin
            return {t - {1'b0, den}, nq[30:0], 1'b1};
        end
        return {t, nq[30:0], 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus slave and configuration
    trace_pkg::state_e st_r, st_nxt;
    logic wr_pend_r, wr_pend_nxt, done_r, done_nxt, unsup_r, unsup_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt, span_r, span_nxt, sweep_r, sweep_nxt;
    logic [13:0] pts_r, pts_nxt, den;
    logic [31:0] fstep_r, tstep_r;
    logic [IW-1:0] idx_r;
    logic [2:0] wmode;
    logic start_go, finish, in_rdy;

    assign den = pts_r - 14'h1;
    assign wmode = HWDATA_I[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    assign start_go = wr_pend_r && wr_addr_r == `OFS_CTRL &&
        HWDATA_I[`CTRL_START] && st_r == trace_pkg::ST_IDLE;

    always_comb begin
        wr_pend_nxt = HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
        wr_addr_nxt = HADDR_I[7:0];
        rdata_nxt = 32'h0;
        if (HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I) begin
            unique case (HADDR_I[7:0])
                `OFS_POINTS: rdata_nxt = {18'h0, pts_r};
                `OFS_SPAN: rdata_nxt = span_r;
                `OFS_SWEEP: rdata_nxt = sweep_r;
                `OFS_STATUS: rdata_nxt = {29'h0, unsup_r, done_r,
                    st_r != trace_pkg::ST_IDLE};
                `OFS_INDEX: rdata_nxt = 32'(idx_r);
                `OFS_FSTEP: rdata_nxt = fstep_r;
                `OFS_TSTEP: rdata_nxt = tstep_r;
                default: rdata_nxt = 32'h0;
            endcase
        end
        pts_nxt = pts_r;
        span_nxt = span_r;
        sweep_nxt = sweep_r;
        unsup_nxt = unsup_r;
        done_nxt = done_r;
        // configuration is frozen while a sweep runs
        if (wr_pend_r && st_r == trace_pkg::ST_IDLE) begin
            if (wr_addr_r == `OFS_POINTS) begin
                if (HWDATA_I < {18'h0, `PTS_MIN}) begin
                    pts_nxt = `PTS_MIN;
                end else if (HWDATA_I > {18'h0, `PTS_MAX}) begin
                    pts_nxt = `PTS_MAX;
                end else begin
                    pts_nxt = HWDATA_I[13:0];
                end
            end
            if (wr_addr_r == `OFS_SPAN) begin
                span_nxt = HWDATA_I;
            end
            if (wr_addr_r == `OFS_SWEEP) begin
                sweep_nxt = HWDATA_I;
            end
        end
        if (start_go) begin
            unsup_nxt = wmode > 3'h3;
        end
        if (wr_pend_r && wr_addr_r == `OFS_STATUS &&
            HWDATA_I[`STAT_DONE]) begin
            done_nxt = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (finish) begin
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h0;
            pts_r <= `PTS_RST;
            span_r <= `SPAN_RST;
            sweep_r <= `SWEEP_RST;
            unsup_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
            pts_r <= pts_nxt;
            span_r <= span_nxt;
            sweep_r <= sweep_nxt;
            unsup_r <= unsup_nxt;
            done_r <= done_nxt;
        end
    end

    assign HRDATA_O = rdata_r;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // sweep engine
    logic [31:0] cnt_r, cnt_nxt, fq_r, fq_nxt, tq_r, tq_nxt;
    logic [31:0] fstep_nxt, tstep_nxt, i_sq, q_sq;
    logic [14:0] frem_r, frem_nxt, trem_r, trem_nxt;
    logic [5:0] dcnt_r, dcnt_nxt;
    logic [IW-1:0] idx_nxt;
    logic [15:0] max_r, max_nxt, min_r, min_nxt, last_r, last_nxt;
    logic [15:0] samp_r, samp_nxt, memo_r, memo_nxt, prev_r, prev_nxt;
    logic [15:0] env, val;
    logic any_r, any_nxt, rose_r, rose_nxt, fell_r, fell_nxt;
    logic took_r, took_nxt, iq_r, iq_nxt, rdy_r, rdy_nxt;
    logic at_end, acc, push, noise;
    trace_pkg::det_mode_e mode_r, mode_nxt;

    assign i_sq = 32'($signed(SAMPLE_I_I) * $signed(SAMPLE_I_I));
    assign q_sq = 32'($signed(SAMPLE_Q_I) * $signed(SAMPLE_Q_I));
    assign env = iq_r ? isqrt(i_sq + q_sq) : SAMPLE_VIDEO_I;
    assign at_end = cnt_r == tstep_r - 32'h1;
    assign acc = SAMPLE_VALID_I && rdy_r;
    assign push = st_r == trace_pkg::ST_RUN && at_end && in_rdy;
    assign finish = push && idx_r == IW'(den);
    assign noise = rose_r && fell_r;

    always_comb begin
        unique case (mode_r)
            trace_pkg::DET_MAX: val = max_r;
            trace_pkg::DET_MIN: val = min_r;
            trace_pkg::DET_NORMAL: begin
                if (noise && !idx_r[0]) begin
                    val = min_r;
                end else if (noise && memo_r > max_r) begin
                    val = memo_r;
                end else begin
                    val = max_r;
                end
            end
            default: val = samp_r;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        {cnt_nxt, idx_nxt, iq_nxt} = {cnt_r, idx_r, iq_r};
        {frem_nxt, fq_nxt, trem_nxt, tq_nxt, dcnt_nxt} =
            {frem_r, fq_r, trem_r, tq_r, dcnt_r};
        {fstep_nxt, tstep_nxt, memo_nxt, prev_nxt} =
            {fstep_r, tstep_r, memo_r, prev_r};
        {max_nxt, min_nxt, last_nxt, samp_nxt} = {max_r, min_r, last_r, samp_r};
        {any_nxt, rose_nxt, fell_nxt, took_nxt} = {any_r, rose_r, fell_r, took_r};
        unique case (st_r)
            trace_pkg::ST_IDLE: begin
                if (start_go) begin
                    st_nxt = trace_pkg::ST_DIV;
                    // other codes than the six run as sample
                    mode_nxt = wmode > 3'h5 ? trace_pkg::DET_SAMPLE :
                        trace_pkg::det_mode_e'(wmode);
                    iq_nxt = HWDATA_I[`CTRL_IQ];
                    {frem_nxt, fq_nxt, trem_nxt, tq_nxt} =
                        {15'h0, span_r, 15'h0, sweep_r};
                    dcnt_nxt = 6'h0;
                end
            end
            trace_pkg::ST_DIV: begin
                {frem_nxt, fq_nxt} = div_step(frem_r, fq_r, den);
                {trem_nxt, tq_nxt} = div_step(trem_r, tq_r, den);
                dcnt_nxt = dcnt_r + 6'h1;
                if (dcnt_r == `DIV_STEPS - 6'h1) begin
                    st_nxt = trace_pkg::ST_RUN;
                    fstep_nxt = fq_nxt;
                    // a one-cycle bucket could accept no sample at all
                    tstep_nxt = tq_nxt < `TSTEP_MIN ? `TSTEP_MIN : tq_nxt;
                    idx_nxt = '0;
                    cnt_nxt = 32'h0;
                    memo_nxt = 16'h0;
                    prev_nxt = 16'h0;
                    {any_nxt, rose_nxt, fell_nxt, took_nxt} = 4'h0;
                end
            end
            trace_pkg::ST_RUN: begin
                if (acc) begin
                    max_nxt = (!any_r || env > max_r) ? env : max_r;
                    min_nxt = (!any_r || env < min_r) ? env : min_r;
                    rose_nxt = rose_r || (any_r && env > last_r);
                    fell_nxt = fell_r || (any_r && env < last_r);
                    last_nxt = env;
                    any_nxt = 1'b1;
                    if (!took_r) begin
                        samp_nxt = env;
                        took_nxt = cnt_r >= (tstep_r >> 1);
                    end
                end
                if (!at_end) begin
                    cnt_nxt = cnt_r + 32'h1;
                end
                if (push) begin
                    cnt_nxt = 32'h0;
                    idx_nxt = idx_r + IW'(1);
                    prev_nxt = val;
                    memo_nxt = (mode_r == trace_pkg::DET_NORMAL && noise &&
                        !idx_r[0]) ? max_r : 16'h0;
                    {max_nxt, min_nxt, last_nxt} = 48'h0;
                    {any_nxt, rose_nxt, fell_nxt, took_nxt} = 4'h0;
                    if (finish) begin
                        st_nxt = trace_pkg::ST_IDLE;
                    end
                end
            end
            default: st_nxt = trace_pkg::ST_IDLE;
        endcase
        // the last cycle of a bucket takes no sample; the source waits
        rdy_nxt = st_nxt == trace_pkg::ST_RUN && cnt_nxt != tstep_nxt - 32'h1;
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            st_r <= trace_pkg::ST_IDLE;
            mode_r <= trace_pkg::DET_SAMPLE;
            {cnt_r, idx_r, iq_r, rdy_r} <= '0;
            {frem_r, fq_r, trem_r, tq_r, dcnt_r} <= '0;
            {fstep_r, tstep_r, memo_r, prev_r} <= '0;
            {max_r, min_r, last_r, samp_r} <= '0;
            {any_r, rose_r, fell_r, took_r} <= 4'h0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            {cnt_r, idx_r, iq_r, rdy_r} <= {cnt_nxt, idx_nxt, iq_nxt, rdy_nxt};
            {frem_r, fq_r, trem_r, tq_r, dcnt_r} <=
                {frem_nxt, fq_nxt, trem_nxt, tq_nxt, dcnt_nxt};
            {fstep_r, tstep_r, memo_r, prev_r} <=
                {fstep_nxt, tstep_nxt, memo_nxt, prev_nxt};
            {max_r, min_r, last_r, samp_r} <=
                {max_nxt, min_nxt, last_nxt, samp_nxt};
            {any_r, rose_r, fell_r, took_r} <=
                {any_nxt, rose_nxt, fell_nxt, took_nxt};
        end
    end

    assign SAMPLE_READY_O = rdy_r;

    ////////////////////////////////////////////////////////////////////////
    // trace write path
    trace_buf #(.W(BW)) u_buf (
        .clk_i(CLOCK_I),
        .srst_i(SRST_I),
        .in_valid_i(push),
        .in_ready_o(in_rdy),
        .in_data_i({finish, idx_r, prev_r, val}),
        .out_valid_o(TRACE_VALID_O),
        .out_ready_i(TRACE_READY_I),
        .out_data_o({TRACE_LAST_O, TRACE_ADDR_O, TRACE_PREV_O, TRACE_DATA_O})
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [45:0] fprod, tprod;
    assign fprod = 46'(fstep_r) * 46'(den);
    assign tprod = 46'(tstep_r) * 46'(den);

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    property p_pts_range;
        pts_r >= `PTS_MIN && pts_r <= `PTS_MAX;
    endproperty
    a_pts_range: assert property (p_pts_range)
        else $error("point count out of range");

    property p_fstep;
        st_r == trace_pkg::ST_RUN |-> fprod <= 46'(span_r) &&
            46'(span_r) - fprod < 46'(den);
    endproperty
    a_fstep: assert property (p_fstep)
        else $error("frequency step wrong");

    property p_tstep;
        st_r == trace_pkg::ST_RUN && tstep_r > `TSTEP_MIN |->
            tprod <= 46'(sweep_r) && 46'(sweep_r) - tprod < 46'(den);
    endproperty
    a_tstep: assert property (p_tstep)
        else $error("bucket time wrong");

    property p_push_time;
        push |-> at_end ##1 cnt_r == 32'h0;
    endproperty
    a_push_time: assert property (p_push_time)
        else $error("bucket closed at wrong count");

    property p_clear;
        push |=> !any_r && !rose_r && !fell_r && !took_r && max_r == 16'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("bucket trackers not cleared");

    property p_max;
        push && mode_r == trace_pkg::DET_MAX |-> val >= min_r &&
            val >= last_r;
    endproperty
    a_max: assert property (p_max)
        else $error("peak below bucket minimum");

    property p_min;
        push && mode_r == trace_pkg::DET_MIN |-> val <= max_r &&
            val <= last_r;
    endproperty
    a_min: assert property (p_min)
        else $error("negative peak above bucket maximum");

    property p_normal;
        push && mode_r == trace_pkg::DET_NORMAL && noise && !idx_r[0] |->
            val == min_r ##1 memo_r == $past(max_r);
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal even bucket wrong");

    property p_start_idx;
        start_go |-> ##33 st_r == trace_pkg::ST_RUN && idx_r == '0;
    endproperty
    a_start_idx: assert property (p_start_idx)
        else $error("sweep did not start at point zero");

    property p_finish;
        finish |=> st_r == trace_pkg::ST_IDLE && done_r;
    endproperty
    a_finish: assert property (p_finish)
        else $error("sweep did not end after last point");

    c_sweep_done: cover property (finish);
    c_normal_odd: cover property (push && mode_r == trace_pkg::DET_NORMAL &&
        noise && idx_r[0]);
    c_stall: cover property (st_r == trace_pkg::ST_RUN && at_end && !in_rdy);
endmodule

// ---- dv/trace_far_end.sv ----
// Purpose: sample source and trace memory facing the bucket detector
// Assumes: BKT samples per bucket, PTS points per sweep
// Notes: hold_i starves the memory side so the write buffer fills up
`timescale 1ns/1ps
module trace_far_end #(
    parameter int BKT = 9,
    parameter int PTS = 101
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic hold_i,
    input wire logic s_ready_i,
    output logic s_valid_o,
    output logic [15:0] s_i_o,
    output logic [15:0] s_q_o,
    output logic [15:0] s_video_o,
    input wire logic t_valid_i,
    input wire logic [12:0] t_addr_i,
    input wire logic [15:0] t_data_i,
    input wire logic [15:0] t_prev_i,
    input wire logic t_last_i,
    output logic t_ready_o
);
    logic [15:0] n_r, v, b, p, tri_v;
    logic [12:0] nxt_r;
    logic [15:0] acc [0:8191];
    logic [15:0] dat [0:8191];
    logic [15:0] prv [0:8191];
    logic lst [0:8191];
    int nwr_r, bad_r;
    logic got_last;
    ////////////////////////////////////////////////////////////////////
    // rise-and-fall buckets, except every fourth which only rises
    always_comb begin
        b = n_r / 16'(BKT);
        p = n_r % 16'(BKT);
        tri_v = (b[1:0] == 2'h3 || p <= 16'h4) ? p : 16'h8 - p;
        v = (16'd200 - b) * 16'h8 + tri_v;
    end
    assign s_valid_o = !srst_i;
    assign s_video_o = v;
    assign s_i_o = 16'h3 * v;
    assign s_q_o = 16'h4 * v;
    assign t_ready_o = !hold_i && !srst_i;
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            n_r <= 16'h0;
            nxt_r <= 13'h0;
            nwr_r <= 0;
            bad_r <= 0;
            got_last <= 1'b0;
        end else begin
            if (s_valid_o && s_ready_i) begin
                acc[n_r] <= v;
                n_r <= (n_r == 16'(BKT * PTS - 1)) ? 16'h0 : n_r + 16'h1;
            end
            if (t_valid_i && t_ready_o) begin
                dat[t_addr_i] <= t_data_i;
                prv[t_addr_i] <= t_prev_i;
                lst[t_addr_i] <= t_last_i;
                nwr_r <= nwr_r + 1;
                if (t_addr_i != nxt_r) bad_r <= bad_r + 1;
                nxt_r <= t_last_i ? 13'h0 : t_addr_i + 13'h1;
                got_last <= t_last_i;
            end
        end
    end
endmodule

// ---- dv/testbench.sv ----
// Purpose: self-checking bench of the trace bucket detector
// Assumes: zero-wait AHB slave, 101 points, 10-cycle buckets
// Notes: expected traces are rebuilt from the samples the source gave
`timescale 1ns/1ps
`include "trace_regs.svh"
module testbench;
    logic clk, srst, hsel, hwrite, hold, hrdy, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic s_val, s_rdy, t_val, t_rdy, t_last;
    logic [15:0] s_i, s_q, s_vid, t_data, t_prev;
    logic [12:0] t_addr;
    int miscompares, total_checks, cyc, nsw;
    logic [4:0] rows [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h14, 5'h15, 5'h09,
        5'h17};
    trace_bucket_detector dut_u (.CLOCK_I(clk), .SRST_I(srst), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
        .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
        .SAMPLE_VALID_I(s_val), .SAMPLE_READY_O(s_rdy), .SAMPLE_I_I(s_i),
        .SAMPLE_Q_I(s_q), .SAMPLE_VIDEO_I(s_vid), .TRACE_VALID_O(t_val),
        .TRACE_READY_I(t_rdy), .TRACE_ADDR_O(t_addr), .TRACE_DATA_O(t_data),
        .TRACE_PREV_O(t_prev), .TRACE_LAST_O(t_last));
    trace_far_end far_u (.clk_i(clk), .srst_i(srst), .hold_i(hold),
        .s_ready_i(s_rdy), .s_valid_o(s_val), .s_i_o(s_i), .s_q_o(s_q),
        .s_video_o(s_vid), .t_valid_i(t_val), .t_addr_i(t_addr),
        .t_data_i(t_data), .t_prev_i(t_prev), .t_last_i(t_last),
        .t_ready_o(t_rdy));
    ////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        total_checks++;
        if (got !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, got);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    // one whole sweep; st starves the memory long enough to fill the buffer
    task sweep(input logic [4:0] r, input logic st);
        logic [15:0] x [9];
        logic [15:0] e, pe, mx, mn, memo;
        logic ro, fe;
        bus(1'b1, `OFS_CTRL, {27'h0, r[3], r[2:0], 1'b1});
        if (st) begin
            hold <= 1'b1;
            repeat (200) @(posedge clk);
            chk("stall ready", {31'h0, s_rdy}, 32'h0);
            chk("stall valid", {31'h0, t_val}, 32'h1);
            // two buffered points, the third bucket end waits
            rchk("stall index", `OFS_INDEX, 32'h2);
            bus(1'b1, `OFS_POINTS, 32'hc8);
            hold <= 1'b0;
        end
        rd = 32'h0;
        while (!rd[`STAT_DONE]) bus(1'b0, `OFS_STATUS, 32'h0);
        chk("busy", {31'h0, rd[`STAT_BUSY]}, 32'h0);
        chk("unsup", {31'h0, rd[`STAT_UNSUP]}, {31'h0, r[4]});
        // the flag stays up from the previous sweep, so count writes too
        while (far_u.nwr_r < 101 * (nsw + 1) || far_u.got_last !== 1'b1)
            @(posedge clk);
        pe = 16'h0;
        memo = 16'h0;
        for (int k = 0; k < 101; k++) begin
            mx = 16'h0;
            mn = 16'hffff;
            ro = 1'b0;
            fe = 1'b0;
            for (int j = 0; j < 9; j++) begin
                x[j] = far_u.acc[k * 9 + j] * (r[3] ? 16'h5 : 16'h1);
                if (x[j] > mx) mx = x[j];
                if (x[j] < mn) mn = x[j];
                if (j > 0 && x[j] > x[j-1]) ro = 1'b1;
                if (j > 0 && x[j] < x[j-1]) fe = 1'b1;
            end
            case (r[2:0])
                3'h1: e = mx;
                3'h2: e = mn;
                3'h3: begin
                    if (ro && fe && k[0] == 1'b0) e = mn;
                    else if (ro && fe) e = (mx > memo) ? mx : memo;
                    else e = mx;
                    memo = (ro && fe && k[0] == 1'b0) ? mx : 16'h0;
                end
                default: e = x[5];
            endcase
            chk("data", {16'h0, far_u.dat[k]}, {16'h0, e});
            chk("prev", {16'h0, far_u.prv[k]}, {16'h0, pe});
            chk("last", {31'h0, far_u.lst[k]}, (k == 100) ? 32'h1 : 32'h0);
            pe = e;
        end
        nsw++;
        chk("order", far_u.bad_r, 32'h0);
        chk("writes", far_u.nwr_r, 101 * nsw);
        rchk("index", `OFS_INDEX, 32'h65);
        bus(1'b1, `OFS_STATUS, 32'h2);
        // unsupported flag stays until the next start
        rchk("done clear", `OFS_STATUS, {29'h0, r[4], 2'h0});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out;
        end
    end
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        hold = 1'b0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("tvalid rst", {31'h0, t_val}, 32'h0);
        chk("sready rst", {31'h0, s_rdy}, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        rchk("points rst", `OFS_POINTS, 32'h65);
        rchk("span rst", `OFS_SPAN, 32'h0);
        rchk("sweep rst", `OFS_SWEEP, 32'h0);
        rchk("status rst", `OFS_STATUS, 32'h0);
        rchk("unmapped", 8'h20, 32'h0);
        bus(1'b1, `OFS_POINTS, 32'h32);
        rchk("points low", `OFS_POINTS, 32'h65);
        bus(1'b1, `OFS_POINTS, 32'h2328);
        rchk("points high", `OFS_POINTS, 32'h2000);
        bus(1'b1, `OFS_POINTS, 32'h65);
        bus(1'b1, `OFS_SPAN, 32'h3e8);
        bus(1'b1, `OFS_SWEEP, 32'h3e8);
        foreach (rows[i]) sweep(rows[i], 1'b0);
        rchk("fstep", `OFS_FSTEP, 32'ha);
        rchk("tstep", `OFS_TSTEP, 32'ha);
        // awkward case: memory stalls mid-sweep and a config write is refused
        sweep(5'h03, 1'b1);
        rchk("points kept", `OFS_POINTS, 32'h65);
        // reset in mid-sweep must restore the status and points registers
        bus(1'b1, `OFS_POINTS, 32'hc8);
        bus(1'b1, `OFS_CTRL, 32'h9);
        repeat (100) @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("tvalid mid", {31'h0, t_val}, 32'h0);
        chk("sready mid", {31'h0, s_rdy}, 32'h0);
        rchk("status mid", `OFS_STATUS, 32'h0);
        rchk("points mid", `OFS_POINTS, 32'h65);
        close_out;
    end
endmodule
